// ### hdl/cci_compare_irq.sv
// Purpose: compare-match event and interrupt for four counter units
// Assumes: counts come from logic on the same clock
// Notes: register read data valid the cycle after the read strobe
`timescale 1ns/100ps
module cci_compare_irq
    import cci_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [cci_pkg::ADDR_W-1:0] addr,
    input wire logic [cci_pkg::DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [cci_pkg::DATA_W-1:0] rdata,
    input wire logic [4*32-1:0] count_value,
    input wire logic [3:0] unit_assigned,
    output logic [3:0] match_event,
    output logic irq
);
    import cci_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic [3:0][1:0] cfg;
        logic [3:0][31:0] first_compare_value;
        logic [3:0][31:0] second_compare_value;
        logic [3:0] prev_match;
        logic [3:0] match_event;
        logic [3:0] status;
        logic [3:0] mask;
        logic [31:0] rdata;
        logic irq;
    } cci_state_t;

    cci_state_t st;
    cci_state_t next_st;
    logic [3:0] match_now;
    logic [3:0] rise;

    // Signed equality of one unit against a value
    function automatic logic cci_eq(input logic signed [31:0] a,
                                    input logic signed [31:0] b);
        return a == b;
    endfunction

    // Effective choice: forced off while unit has no fast input
    function automatic logic [1:0] cci_eff(input logic [1:0] c,
                                           input logic assigned);
        return assigned ? c : CCI_MODE_OFF;
    endfunction

    // ==========================================================
    // Match detection
    always_comb
    begin
        for (int u = 0; u < NUM_UNITS; u++)
        begin
            logic e0;
            logic e1;
            e0 = cci_eq(count_value[u*32 +: 32], st.first_compare_value[u]);
            e1 = cci_eq(count_value[u*32 +: 32], st.second_compare_value[u]);
            unique case (cci_eff(st.cfg[u], unit_assigned[u]))
                CCI_MODE_FIRST: match_now[u] = e0;
                CCI_MODE_EITHER: match_now[u] = e0 | e1;
                default: match_now[u] = 1'b0;
            endcase
        end
        rise = match_now & ~st.prev_match;
    end

    // ==========================================================
    // Next state and register bus
    always_comb
    begin
        logic [3:0] idx;
        next_st = st;
        idx = 4'(addr[3:2]);
        next_st.prev_match = match_now;
        next_st.match_event = rise;
        // sticky request; set beats read clear
        next_st.status = st.status;
        if (rd_en && addr == OFF_STATUS)
            next_st.status = 4'h0;
        next_st.status = next_st.status | rise;
        next_st.irq = |(next_st.status & st.mask);
        next_st.rdata = 32'h0;
        if (wr_en)
        begin
            if (addr == OFF_CFG)
            begin
                // per-unit choice, illegal code stored as off
                for (int u = 0; u < NUM_UNITS; u++)
                    next_st.cfg[u] = (wdata[u*2 +: 2] == 2'h3)
                        ? CFG_RESET : wdata[u*2 +: 2];
            end
            else if (addr == OFF_MASK)
                next_st.mask = wdata[3:0];
            else if (addr[7:4] == OFF_FIRST_BASE[7:4])
                next_st.first_compare_value[idx[1:0]] = wdata;
            else if (addr[7:4] == OFF_SECOND_BASE[7:4])
                next_st.second_compare_value[idx[1:0]] = wdata;
        end
        if (rd_en)
        begin
            if (addr == OFF_CFG)
                for (int u = 0; u < NUM_UNITS; u++)
                    next_st.rdata[u*2 +: 2] =
                        cci_eff(st.cfg[u], unit_assigned[u]);
            else if (addr == OFF_STATUS)
                next_st.rdata[3:0] = st.status;
            else if (addr == OFF_MASK)
                next_st.rdata[3:0] = st.mask;
            else if (addr[7:4] == OFF_FIRST_BASE[7:4])
                next_st.rdata = st.first_compare_value[idx[1:0]];
            else if (addr[7:4] == OFF_SECOND_BASE[7:4])
                next_st.rdata = st.second_compare_value[idx[1:0]];
        end
    end

    // ==========================================================
    // State register; four units
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.mask <= MASK_RESET;
        end
        else
            st <= next_st;
    end

    assign rdata = st.rdata;
    assign match_event = st.match_event;
    assign irq = st.irq;

    // ==========================================================
    // Assertions
    // Checks sit on internal state as well as on the pins, so a fault
    // in the decode shows here before it reaches the handler side.

    // Status bit of unit two, watched by the sticky check
    logic status_set_2;
    assign status_set_2 = st.status[2];

    a_event_onset: assert property (
        @(posedge clock) disable iff (rst)
        rise[0] |=> match_event[0])
        else $error("event missing after match onset");

    a_event_single: assert property (
        @(posedge clock) disable iff (rst)
        match_event[1] |=> !match_event[1])
        else $error("event longer than one cycle");

    a_unassigned_quiet: assert property (
        @(posedge clock) disable iff (rst)
        !unit_assigned[2] |-> !match_now[2])
        else $error("match on unassigned unit");

    a_first_mode: assert property (
        @(posedge clock) disable iff (rst)
        (unit_assigned[0] && st.cfg[0] == CCI_MODE_FIRST)
        |-> match_now[0] == (count_value[31:0]
            == st.first_compare_value[0]))
        else $error("first mode mismatch");

    a_either_mode: assert property (
        @(posedge clock) disable iff (rst)
        (unit_assigned[1] && st.cfg[1] == CCI_MODE_EITHER
         && count_value[63:32] == st.second_compare_value[1])
        |-> match_now[1])
        else $error("either mode missed second value");

    a_off_mode: assert property (
        @(posedge clock) disable iff (rst)
        st.cfg[3] == CCI_MODE_OFF |-> !match_now[3])
        else $error("disabled unit matched");

    // event always leaves a status bit
    a_status_sticky: assert property (
        @(posedge clock) disable iff (rst)
        match_event[2] |-> status_set_2)
        else $error("status not set with event");

    a_irq_level: assert property (
        @(posedge clock) disable iff (rst)
        ##1 irq == $past(|(next_st.status & st.mask)))
        else $error("irq does not follow masked status");

    // first values only change on a write
    a_values_held: assert property (
        @(posedge clock) disable iff (rst)
        !wr_en |=> $stable(st.first_compare_value))
        else $error("compare value changed without write");

    a_signed_eq: assert property (
        @(posedge clock) disable iff (rst)
        (unit_assigned[3] && st.cfg[3] == CCI_MODE_FIRST
         && count_value[127:96] == st.first_compare_value[3])
        |-> match_now[3])
        else $error("signed equality missed");

    // second values only change on a write
    a_second_held: assert property (
        @(posedge clock) disable iff (rst)
        !wr_en |=> $stable(st.second_compare_value))
        else $error("second value changed without write");

    // choice only changes on a write
    a_cfg_held: assert property (
        @(posedge clock) disable iff (rst)
        !wr_en |=> $stable(st.cfg))
        else $error("choice changed without write");

    a_cfg_legal: assert property (
        @(posedge clock) disable iff (rst)
        st.cfg[0] != 2'h3 && st.cfg[1] != 2'h3
        && st.cfg[2] != 2'h3 && st.cfg[3] != 2'h3)
        else $error("illegal choice stored");

    // first mode ignores the second value
    a_first_ignores: assert property (
        @(posedge clock) disable iff (rst)
        (st.cfg[2] == CCI_MODE_FIRST
         && count_value[95:64] != st.first_compare_value[2])
        |-> !match_now[2])
        else $error("first mode fired on second value");

    // either mode still takes first value
    a_either_first: assert property (
        @(posedge clock) disable iff (rst)
        (unit_assigned[1] && st.cfg[1] == CCI_MODE_EITHER
         && count_value[63:32] == st.first_compare_value[1])
        |-> match_now[1])
        else $error("either mode missed first value");

    // no unit matches without a fast input
    a_unassigned_all: assert property (
        @(posedge clock) disable iff (rst)
        (match_now & ~unit_assigned) == 4'h0)
        else $error("unassigned unit matched");

    // each event line comes from its own unit
    a_event_own_unit: assert property (
        @(posedge clock) disable iff (rst)
        |match_event |-> (match_event & ~$past(match_now)) == 4'h0)
        else $error("event without its unit matching");

    // no unit pulses twice in a row
    a_event_single_all: assert property (
        @(posedge clock) disable iff (rst)
        ##1 (match_event & $past(match_event)) == 4'h0)
        else $error("event line held two cycles");

    // a fully masked block stays silent
    a_irq_masked: assert property (
        @(posedge clock) disable iff (rst)
        ##1 $past(st.mask) == 4'h0 |-> !irq)
        else $error("irq with all units masked");

    // status read clears when nothing new arrives
    a_status_clear: assert property (
        @(posedge clock) disable iff (rst)
        (rd_en && addr == OFF_STATUS && rise == 4'h0)
        |=> st.status == 4'h0)
        else $error("status not cleared by read");

    // status holds without read or event
    a_status_hold: assert property (
        @(posedge clock) disable iff (rst)
        (!(rd_en && addr == OFF_STATUS) && rise == 4'h0)
        |=> $stable(st.status))
        else $error("status changed on its own");

    // read data stand only after a read strobe
    a_rdata_idle: assert property (
        @(posedge clock) disable iff (rst)
        !rd_en |=> rdata == 32'h0)
        else $error("read data without read strobe");

    c_first_event: cover property (@(posedge clock) disable iff (rst)
        match_event[0]);
    c_either_event: cover property (@(posedge clock) disable iff (rst)
        st.cfg[1] == CCI_MODE_EITHER && match_event[1]);
    c_irq_raised: cover property (@(posedge clock) disable iff (rst)
        irq);
    c_all_events: cover property (@(posedge clock) disable iff (rst)
        &match_event);
    c_masked_event: cover property (@(posedge clock) disable iff (rst)
        match_event[2] && !st.mask[2]);

endmodule // cci_compare_irq

// ### hdl/cci_pkg.sv
// Purpose: constants and types for the counter compare interrupt block
// Assumes: single 50 MHz clock, asynchronous active-high reset
// Notes: register map lives here, offsets are byte addresses
// Notes on behaviour
// - Each unit holds two comparison values
// - Matching enabled unit raises an interrupt request; irq pin only with its mask bit set, and mask resets to 0
// - Per-unit setting, default disabled; first-value mode
// - Either-value mode fires on either match
// - Setting held disabled unless unit assigned
// - Each unit has its own event output
// - Four units, indexed zero to three
// - Count and values compared as signed 32-bit
package cci_pkg;

    // ==========================================================
    // Sizes
    localparam int unsigned NUM_UNITS = 4;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFF_CFG = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_FIRST_BASE = 8'h10;
    localparam logic [7:0] OFF_SECOND_BASE = 8'h20;

    // ==========================================================
    // Field layout and reset values
    localparam int unsigned CFG_FIELD_W = 2;
    localparam logic [1:0] CFG_RESET = 2'h0;
    localparam logic [3:0] MASK_RESET = 4'h0;
    localparam logic [31:0] VALUE_RESET = 32'h0;

    // Interrupt choice per unit
    typedef enum logic [1:0] {
        CCI_MODE_OFF = 2'h0,
        CCI_MODE_FIRST = 2'h1,
        CCI_MODE_EITHER = 2'h2
    } cci_mode_t;

endpackage : cci_pkg

// ### tb/cci_task_sched.sv
// Purpose: handler side, counts match events of each unit
// Assumes: events are one-cycle pulses on clock
// Notes: never stalls; a long pulse counts once per cycle
`timescale 1ns/100ps
module cci_task_sched
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] match_event,
    output logic [3:0][7:0] runs
);
    // ==========================================
    // Handler runs, one per event cycle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            runs <= '0;
        end
        else
        begin
            for (int u = 0; u < 4; u++)
            begin
                runs[u] <= runs[u] + 8'(match_event[u]);
            end
        end
    end
endmodule // cci_task_sched

// ### tb/counter_compare_interrupt_test.sv
// Purpose: self-checking bench for the compare interrupt block
// Assumes: read data stand one cycle after the strobe
// Notes: counts sit away from the values until a match is wanted
`timescale 1ns/100ps
module counter_compare_interrupt_test;
    import cci_pkg::*;
    logic clock = 0, rst = 1, wr_en = 0, rd_en = 0, irq;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [127:0] count_value = {4{32'h5}};
    logic [3:0] unit_assigned = 4'hf, match_event;
    logic [3:0][7:0] runs;
    int fail_count = 0, n_tests = 0;
    // ==========================================
    // Clock, block and handler model
    initial
    begin
        forever #10 clock = ~clock;
    end
    cci_compare_irq i_cci_compare_irq (.clock(clock), .rst(rst),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata(rdata), .count_value(count_value),
        .unit_assigned(unit_assigned), .match_event(match_event), .irq(irq));
    cci_task_sched i_cci_task_sched (.clock(clock), .rst(rst),
        .match_event(match_event), .runs(runs));
    // ==========================================
    // Access tasks
    task chk(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {wr_en, addr, wdata} <= {1'b1, a, d};
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clock);
        {rd_en, addr} <= {1'b1, a};
        @(posedge clock);
        rd_en <= 1'b0;
        #1 chk(what, rdata, exp);
    endtask
    // Settle time covers onset plus registered pulse
    task setc(input int u, input logic [31:0] v);
        @(posedge clock);
        count_value[u*32+:32] <= v;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // Watchdog, far beyond the hundred or so cycles needed
    initial
    begin
        repeat (3000) @(posedge clock);
        fail_count++;
        complete_run;
    end
    // ==========================================
    // Test sequence
    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rd(OFF_CFG, 32'h0, "cfg reset");
        rd(OFF_FIRST_BASE, 32'h0, "first reset");
        $display("test reset done");
        for (int u = 0; u < 4; u++)
        begin
            wr(OFF_FIRST_BASE + 8'(4 * u), 32'h64 + u);
            wr(OFF_SECOND_BASE + 8'(4 * u), 32'hc8 + u);
        end
        wr(OFF_MASK, 32'hf);
        wr(OFF_CFG, 32'h55);
        rd(OFF_SECOND_BASE + 8'hc, 32'hcb, "second value");
        rd(OFF_CFG, 32'h55, "cfg first");
        // Held equality must give one pulse, each unit in turn, runs checked for that unit only
        for (int u = 0; u < 4; u++)
        begin
            setc(u, 32'h64 + u);
            chk("runs", 32'(runs[u]), 32'h1);
        end
        chk("irq", 32'(irq), 32'h1);
        rd(OFF_STATUS, 32'hf, "status");
        rd(OFF_STATUS, 32'h0, "status clear");
        chk("irq clear", 32'(irq), 32'h0);
        $display("test first mode done");
        setc(0, 32'hc8);
        chk("first only", 32'(runs[0]), 32'h1);
        wr(OFF_CFG, 32'h56);
        setc(0, 32'hc8);
        chk("either", 32'(runs[0]), 32'h2);
        wr(OFF_FIRST_BASE + 8'h4, 32'h80000000);
        setc(1, 32'h80000000);
        chk("signed", 32'(runs[1]), 32'h2);
        rd(OFF_STATUS, 32'h3, "status two");
        $display("test either mode done");
        @(posedge clock);
        unit_assigned <= 4'he;
        rd(OFF_CFG, 32'h54, "cfg unassigned");
        setc(0, 32'h64);
        chk("unassigned", 32'(runs[0]), 32'h2);
        wr(OFF_MASK, 32'hb);
        setc(2, 32'h5);
        setc(2, 32'h66);
        chk("refire", 32'(runs[2]), 32'h2);
        chk("irq masked", 32'(irq), 32'h0);
        rd(OFF_STATUS, 32'h4, "status masked");
        rd(8'hfc, 32'h0, "unmapped");
        $display("test assign and mask done");
        complete_run;
    end
endmodule // counter_compare_interrupt_test
